// ==== src/fuse_prog_pkg.sv ====
// package: timing counts, array shape and tape characters for the fuse programmer
package fuse_prog_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    // programming timing, in the printed units
    localparam int unsigned FIRST_PULSE_US  = 50;
    localparam int unsigned NEXT_PULSE_MS   = 5;
    localparam int unsigned EDGE_DELAY_NS   = 1000;
    localparam int unsigned TOTAL_LIMIT_MS  = 400;
    localparam int unsigned HEAT_LIMIT_S    = 5;
    localparam int unsigned COOL_S          = 5;
    // derived cycle counts
    localparam int unsigned FIRST_PULSE_CYC = FIRST_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned NEXT_PULSE_CYC  = NEXT_PULSE_MS * (CLK_HZ / 1_000);
    localparam int unsigned EDGE_DELAY_CYC  = EDGE_DELAY_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned TOTAL_LIMIT_CYC = TOTAL_LIMIT_MS * (CLK_HZ / 1_000);
    localparam longint unsigned HEAT_LIMIT_CYC = longint'(HEAT_LIMIT_S) * CLK_HZ;
    localparam longint unsigned COOL_CYC       = longint'(COOL_S) * CLK_HZ;
    // array shape
    localparam int unsigned WORD_BITS       = 4;
    localparam int unsigned ADDR_BITS       = 8;
    localparam int unsigned WORD_COUNT      = 256;
    // tape characters, seven data bits
    localparam logic [6:0] CH_BEGIN  = 7'h42;
    localparam logic [6:0] CH_FINISH = 7'h46;
    localparam logic [6:0] CH_HIGH   = 7'h50;
    localparam logic [6:0] CH_LOW    = 7'h4E;
    localparam logic [6:0] CH_RUBOUT = 7'h7F;
    localparam int unsigned RUBOUT_MIN = 25;
endpackage : fuse_prog_pkg

// ==== src/pattern_mem.sv ====
// pattern memory: 256 words of 4 bits, registered read
`timescale 1ns/1ns
`default_nettype none
module pattern_mem (
    input  wire logic       i_sys_clk,
    // write port
    input  wire logic       i_we,
    input  wire logic [7:0] i_waddr,
    input  wire logic [3:0] i_wdata,
    // read port
    input  wire logic [7:0] i_raddr,
    output logic      [3:0] o_rdata
);
    logic [3:0] mem [0:255];

    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : pattern_mem
`default_nettype wire

// ==== src/tape_parser.sv ====
// tape parser: leader, words, rubout cancel, parity, trailer
`timescale 1ns/1ns
`default_nettype none
module tape_parser (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // character stream
    input  wire logic       i_char_valid,
    input  wire logic [7:0] i_char,
    input  wire logic       i_parity_check,
    // parsed words
    output logic            o_word_we,
    output logic      [7:0] o_word_addr,
    output logic      [3:0] o_word_data,
    // status
    output logic            o_tape_done,
    output logic            o_format_err,
    output logic            o_parity_err
);
    typedef enum logic [1:0] {P_LEADER = 2'b00, P_GAP = 2'b01, P_WORD = 2'b11, P_END = 2'b10} pstate_t;

    pstate_t    state_reg;
    logic [4:0] lead_cnt_reg;
    logic [2:0] nchar_reg;
    logic [3:0] bits_reg;
    logic [8:0] addr_reg;

    wire  [6:0] ch        = i_char[6:0];
    wire        par_bad   = i_parity_check & (^i_char);
    wire        is_rub    = (ch == fuse_prog_pkg::CH_RUBOUT);
    wire        is_lvl    = (ch == fuse_prog_pkg::CH_HIGH) | (ch == fuse_prog_pkg::CH_LOW);
    wire        lvl_bit   = (ch == fuse_prog_pkg::CH_HIGH);
    wire        lead_ok   = (lead_cnt_reg >= 5'(fuse_prog_pkg::RUBOUT_MIN));

    always_ff @(posedge i_sys_clk) begin
        o_word_we <= 1'b0;
        if (!i_rst_n) begin
            state_reg    <= P_LEADER;
            lead_cnt_reg <= '0;
            nchar_reg    <= '0;
            bits_reg     <= '0;
            addr_reg     <= '0;
            o_word_addr  <= '0;
            o_word_data  <= '0;
            o_tape_done  <= 1'b0;
            o_format_err <= 1'b0;
            o_parity_err <= 1'b0;
        end else if (i_char_valid) begin
            if (par_bad) begin
                o_parity_err <= 1'b1;
            end
            unique case (state_reg)
                P_LEADER: begin
                    if (is_rub) begin
                        if (!lead_ok) lead_cnt_reg <= lead_cnt_reg + 5'h01;
                    end else if (lead_ok) begin
                        state_reg <= P_GAP;
                        if (ch == fuse_prog_pkg::CH_BEGIN) begin
                            state_reg <= P_WORD;
                            nchar_reg <= '0;
                        end
                    end
                end
                P_GAP: begin
                    if (ch == fuse_prog_pkg::CH_BEGIN) begin
                        state_reg <= P_WORD;
                        nchar_reg <= '0;
                    end
                end
                P_WORD: begin
                    if (is_rub) begin
                        state_reg <= P_GAP;
                    end else if (is_lvl && nchar_reg < 3'h4) begin
                        bits_reg  <= {bits_reg[2:0], lvl_bit};
                        nchar_reg <= nchar_reg + 3'h1;
                    end else if (ch == fuse_prog_pkg::CH_FINISH && nchar_reg == 3'h4) begin
                        o_word_we   <= 1'b1;
                        o_word_addr <= addr_reg[7:0];
                        o_word_data <= bits_reg;
                        addr_reg    <= addr_reg + 9'h001;
                        state_reg   <= (addr_reg == 9'h0FF) ? P_END : P_GAP;
                        o_tape_done <= (addr_reg == 9'h0FF);
                    end else begin
                        o_format_err <= 1'b1;
                        state_reg    <= P_GAP;
                    end
                end
                P_END: begin
                    // trailer and anything after it is ignored except by the parity check
                end
            endcase
        end
    end
endmodule : tape_parser
`default_nettype wire

// ==== src/fuse_prog_sequencer.sv ====
// fuse PROM programmer: pulse, verify, retry, cooldown and final readback
`timescale 1ns/1ns
`default_nettype none
module fuse_prog_sequencer #(
    parameter longint unsigned HEAT_LIMIT_CYC = fuse_prog_pkg::HEAT_LIMIT_CYC,
    parameter longint unsigned COOL_CYC       = fuse_prog_pkg::COOL_CYC,
    parameter int unsigned     TOTAL_CYC      = fuse_prog_pkg::TOTAL_LIMIT_CYC,
    parameter int unsigned     NEXT_CYC       = fuse_prog_pkg::NEXT_PULSE_CYC
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // tape input
    input  wire logic       i_char_valid,
    input  wire logic [7:0] i_char,
    input  wire logic       i_parity_check,
    // user control
    input  wire logic       i_start,
    // prom pins
    output logic      [7:0] o_word_address_lines,
    output logic            o_gate_select_high,
    output logic            o_gate_program_level,
    output logic            o_second_chip_select,
    output logic      [3:0] o_output_program_level,
    output logic            o_load_sense,
    output logic            o_power_on,
    input  wire logic [3:0] i_prom_data,
    // status
    output logic            o_busy,
    output logic            o_done,
    output logic            o_fail,
    output logic            o_extra_fuse,
    output logic            o_cooling,
    output logic            o_tape_done,
    output logic            o_format_err,
    output logic            o_parity_err
);
    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE   = 4'h0, S_FETCH  = 4'h1, S_CHECK  = 4'h3, S_GATE   = 4'h2,
        S_SUPPLY = 4'h6, S_PULSE  = 4'h7, S_DROP   = 4'h5, S_ENABLE = 4'h4,
        S_VERIFY = 4'hC, S_NEXT   = 4'hD, S_COOL   = 4'hF, S_READ   = 4'hE,
        S_RCMP   = 4'hA, S_DONE   = 4'hB, S_FAIL   = 4'h9
    } state_t;

    state_t      state_reg;
    logic [7:0]  addr_reg;
    logic [1:0]  bit_reg;
    logic        first_reg;
    logic [31:0] tmr_reg;
    logic [31:0] link_time_reg;
    logic [39:0] heat_reg;
    logic        fail_reg;
    logic        extra_reg;

    // ------------------------------------------------------------
    // parser and pattern store
    // ------------------------------------------------------------
    logic       pw_we;
    logic [7:0] pw_addr;
    logic [3:0] pw_data;
    logic [3:0] want;

    tape_parser u_parser (
        .i_sys_clk      (i_sys_clk),
        .i_rst_n        (i_rst_n),
        .i_char_valid   (i_char_valid),
        .i_char         (i_char),
        .i_parity_check (i_parity_check),
        .o_word_we      (pw_we),
        .o_word_addr    (pw_addr),
        .o_word_data    (pw_data),
        .o_tape_done    (o_tape_done),
        .o_format_err   (o_format_err),
        .o_parity_err   (o_parity_err)
    );

    pattern_mem u_mem (
        .i_sys_clk (i_sys_clk),
        .i_we      (pw_we),
        .i_waddr   (pw_addr),
        .i_wdata   (pw_data),
        .i_raddr   (addr_reg),
        .o_rdata   (want)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic [3:0] onehot(input logic [1:0] b);
        onehot = 4'h1 << b;
    endfunction : onehot

    wire        tmr_zero   = (tmr_reg == 32'h0);
    wire        sense_bit  = i_prom_data[bit_reg];
    wire        want_bit   = want[bit_reg];
    wire        need_pulse = want_bit & ~sense_bit;
    wire        last_bit   = (bit_reg == 2'h3);
    wire        last_addr  = (addr_reg == 8'hFF);
    wire        heating    = (state_reg == S_PULSE);
    wire        heat_over  = (heat_reg >= 40'(HEAT_LIMIT_CYC));
    wire        link_over  = (link_time_reg >= TOTAL_CYC);
    wire [31:0] edge_cyc   = 32'(fuse_prog_pkg::EDGE_DELAY_CYC);
    wire [31:0] pulse_cyc  = first_reg ? 32'(fuse_prog_pkg::FIRST_PULSE_CYC)
                                       : 32'(NEXT_CYC);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_reg     <= S_IDLE;
            addr_reg      <= '0;
            bit_reg       <= '0;
            first_reg     <= 1'b1;
            tmr_reg       <= '0;
            link_time_reg <= '0;
            heat_reg      <= '0;
            fail_reg      <= 1'b0;
            extra_reg     <= 1'b0;
        end else begin
            if (!tmr_zero) tmr_reg <= tmr_reg - 32'h1;
            if (heating) begin
                heat_reg      <= heat_reg + 40'h1;
                link_time_reg <= link_time_reg + 32'h1;
            end
            unique case (state_reg)
                S_IDLE: if (i_start) begin
                    addr_reg  <= '0;
                    bit_reg   <= '0;
                    fail_reg  <= 1'b0;
                    extra_reg <= 1'b0;
                    state_reg <= S_FETCH;
                end
                S_FETCH: begin                                      // memory and prom settle
                    first_reg     <= 1'b1;
                    link_time_reg <= '0;
                    tmr_reg       <= edge_cyc;
                    state_reg     <= S_CHECK;
                end
                S_CHECK: if (tmr_zero) begin
                    state_reg <= need_pulse ? S_GATE : S_NEXT;
                    tmr_reg   <= edge_cyc;
                end
                S_GATE: if (tmr_zero) begin
                    state_reg <= S_SUPPLY;
                    tmr_reg   <= edge_cyc;
                end
                S_SUPPLY: if (tmr_zero) begin
                    state_reg <= S_PULSE;
                    tmr_reg   <= pulse_cyc;
                end
                S_PULSE: if (tmr_zero) begin
                    state_reg <= S_DROP;
                    tmr_reg   <= edge_cyc;
                end
                S_DROP: if (tmr_zero) begin
                    state_reg <= S_ENABLE;
                    tmr_reg   <= edge_cyc;
                end
                S_ENABLE: if (tmr_zero) begin
                    state_reg <= S_VERIFY;
                    tmr_reg   <= edge_cyc;
                end
                S_VERIFY: if (tmr_zero) begin
                    first_reg <= 1'b0;
                    tmr_reg   <= edge_cyc;
                    if (sense_bit) state_reg <= S_NEXT;
                    else if (link_over) begin
                        fail_reg  <= 1'b1;
                        state_reg <= S_FAIL;
                    end else if (heat_over) begin
                        tmr_reg   <= 32'(COOL_CYC);
                        state_reg <= S_COOL;
                    end else state_reg <= S_GATE;
                end
                S_COOL: if (tmr_zero) begin
                    heat_reg  <= '0;
                    tmr_reg   <= edge_cyc;
                    state_reg <= S_GATE;
                end
                S_NEXT: begin
                    bit_reg <= bit_reg + 2'h1;
                    if (last_bit) begin
                        addr_reg  <= addr_reg + 8'h01;
                        state_reg <= last_addr ? S_READ : S_FETCH;
                    end else state_reg <= S_FETCH;
                    if (last_bit && last_addr) tmr_reg <= edge_cyc;
                end
                S_READ: if (tmr_zero) begin
                    state_reg <= S_RCMP;
                end
                S_RCMP: begin
                    if (i_prom_data != want) extra_reg <= 1'b1;
                    addr_reg  <= addr_reg + 8'h01;
                    tmr_reg   <= edge_cyc;
                    state_reg <= last_addr ? S_DONE : S_READ;
                end
                S_DONE: if (i_start) state_reg <= S_IDLE;
                S_FAIL: if (i_start) state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drive, registered so edges stay clean
    // ------------------------------------------------------------
    wire gate_hi  = (state_reg == S_GATE) | (state_reg == S_SUPPLY) | (state_reg == S_PULSE)
                  | (state_reg == S_DROP);
    wire sup_on   = (state_reg == S_SUPPLY) | (state_reg == S_PULSE);
    wire selected = ~gate_hi;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_word_address_lines   <= '0;
            o_gate_select_high     <= 1'b0;
            o_gate_program_level   <= 1'b0;
            o_second_chip_select   <= 1'b1;
            o_output_program_level <= '0;
            o_load_sense           <= 1'b0;
            o_power_on             <= 1'b0;
        end else begin
            o_word_address_lines   <= addr_reg;
            o_gate_select_high     <= gate_hi;
            o_gate_program_level   <= (state_reg == S_PULSE);
            o_second_chip_select   <= ~selected;
            o_output_program_level <= sup_on ? onehot(bit_reg) : 4'h0;
            o_load_sense           <= (state_reg == S_VERIFY);
            o_power_on             <= (state_reg != S_IDLE) & (state_reg != S_COOL);
        end
    end

    assign o_busy       = (state_reg != S_IDLE) & (state_reg != S_DONE) & (state_reg != S_FAIL);
    assign o_done       = (state_reg == S_DONE);
    assign o_fail       = fail_reg;
    assign o_extra_fuse = extra_reg;
    assign o_cooling    = (state_reg == S_COOL);
endmodule : fuse_prog_sequencer
`default_nettype wire

// ==== test/fuse_prog_monitor.sv ====
// checker: prom pin sequencing of the fuse programmer
`timescale 1ns/1ns
`default_nettype none
module fuse_prog_monitor #(
    parameter int unsigned NEXT_CYC = 500
) (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic [7:0] o_word_address_lines,
    input wire logic       o_gate_select_high,
    input wire logic       o_gate_program_level,
    input wire logic [3:0] o_output_program_level,
    input wire logic       o_load_sense,
    input wire logic       o_power_on,
    input wire logic       o_done,
    input wire logic       o_fail,
    input wire logic       o_cooling
);
    logic [15:0] pulse_len_reg;
    logic [15:0] gap_reg;
    logic [6:0]  pins_reg;
    logic [6:0]  pins_now;
    assign pins_now = {o_gate_select_high, o_gate_program_level, o_output_program_level, o_load_sense};
    // gap saturates so long idle spans cannot wrap into a false short gap
    always_ff @(posedge i_sys_clk) begin
        pulse_len_reg <= (i_rst_n && o_gate_program_level) ? pulse_len_reg + 16'h0001 : 16'h0000;
        pins_reg      <= pins_now;
        gap_reg       <= (!i_rst_n || pins_now != pins_reg) ? 16'h0000
                         : ((gap_reg == 16'hFFFF) ? gap_reg : gap_reg + 16'h0001);
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_gate_before_supply: assert property ($rose(|o_output_program_level) |-> $past(o_gate_select_high))
        else $error("supply applied before gate select high");
    a_pulse_addr_held: assert property (o_gate_program_level |-> $onehot(o_output_program_level) && $stable(o_word_address_lines))
        else $error("fuse pulse without one supplied output or stable address");
    a_one_link_only: assert property ($onehot0(o_output_program_level))
        else $error("more than one output supplied");
    a_pulse_width_ok: assert property ($fell(o_gate_program_level) |->
        (pulse_len_reg >= fuse_prog_pkg::FIRST_PULSE_CYC && pulse_len_reg <= 2 * fuse_prog_pkg::FIRST_PULSE_CYC)
        || (pulse_len_reg >= NEXT_CYC && pulse_len_reg <= 3 * NEXT_CYC))
        else $error("fuse pulse width out of range");
    a_edge_spacing_min: assert property ((pins_now != pins_reg) |-> gap_reg >= 16'h0005)
        else $error("programming edges too close");
    a_verify_isolated: assert property (o_load_sense |-> !o_gate_program_level && o_output_program_level == 4'h0)
        else $error("sense while supply or pulse applied");
    a_cool_unpowered: assert property ($past(o_cooling) && o_cooling |-> !o_power_on && !o_gate_program_level)
        else $error("power present during cooldown");
    a_fail_quiet: assert property (o_fail && $past(o_fail, 2) |-> !o_gate_program_level && o_output_program_level == 4'h0)
        else $error("programming continues after failure");
    c_pulse: cover property ($fell(o_gate_program_level));
    c_cool: cover property ($rose(o_cooling));
    c_fail: cover property ($rose(o_fail));
    c_done: cover property ($rose(o_done));
endmodule : fuse_prog_monitor
bind fuse_prog_sequencer fuse_prog_monitor #(.NEXT_CYC(NEXT_CYC)) u_monitor (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .o_word_address_lines(o_word_address_lines),
    .o_gate_select_high(o_gate_select_high), .o_gate_program_level(o_gate_program_level),
    .o_output_program_level(o_output_program_level), .o_load_sense(o_load_sense),
    .o_power_on(o_power_on), .o_done(o_done), .o_fail(o_fail), .o_cooling(o_cooling));
`default_nettype wire

// ==== test/prom_model.sv ====
// partner model: 256 x 4 fusible-link prom programmed through its pins
`timescale 1ns/1ns
`default_nettype none
module prom_model #(
    parameter logic [7:0]  STRONG_ADDR   = 8'h03,
    parameter int unsigned STRONG_PULSES = 3
) (
    input  wire logic       i_sys_clk,
    // pins from the programmer
    input  wire logic [7:0] i_addr,
    input  wire logic       i_gate_high,
    input  wire logic       i_gate_prog,
    input  wire logic       i_cs2,
    input  wire logic [3:0] i_supply,
    input  wire logic       i_power,
    input  wire logic       i_stuck,
    // data pins
    output logic      [3:0] o_data
);
    logic [3:0] blown_reg [256];
    logic       gate_prog_reg;
    logic [3:0] supply_reg;
    int         strong_hits;
    logic       enabled;
    // open collector: a deselected output floats up to the pull-up level
    assign enabled = i_power && !i_gate_high && !i_gate_prog && !i_cs2;
    assign o_data  = enabled ? blown_reg[i_addr] : 4'hF;
    initial begin
        for (int i = 0; i < 256; i++) blown_reg[i] = 4'h0;
        strong_hits   = 0;
        gate_prog_reg = 1'b0;
        supply_reg    = 4'h0;
    end
    // a link opens at the end of a pulse with its output supplied;
    // supply drops on the same edge as the pulse, so use its last value
    always @(posedge i_sys_clk) begin
        gate_prog_reg <= i_gate_prog;
        supply_reg    <= i_supply;
        if (gate_prog_reg && !i_gate_prog && i_power && !i_stuck && $onehot(supply_reg)) begin
            if (i_addr == STRONG_ADDR) strong_hits = strong_hits + 1;
            if (i_addr != STRONG_ADDR || strong_hits >= STRONG_PULSES) blown_reg[i_addr] <= blown_reg[i_addr] | supply_reg;
        end
    end
endmodule : prom_model
`default_nettype wire

// ==== test/fuse_prog_sequencer_tb_top.sv ====
// testbench: tape loading, programming with retries, failure and cooldown
`timescale 1ns/1ns
`default_nettype none
module fuse_prog_sequencer_tb_top;
    logic       i_sys_clk = 1'b0;
    logic       i_rst_n, i_char_valid, i_parity_check, i_start, stuck, cool_seen;
    logic [7:0] i_char, addr;
    logic [3:0] prom_data, supply;
    logic       gsh, gpl, cs2, load, pwr, busy, done, fail, extra, cooling, tdone, ferr, perr;
    int         errors = 0;
    int         tests_run = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (cooling === 1'b1) cool_seen <= 1'b1;
    fuse_prog_sequencer #(.HEAT_LIMIT_CYC(64'd3000), .COOL_CYC(64'd100), .TOTAL_CYC(5000), .NEXT_CYC(500)) dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_char_valid(i_char_valid), .i_char(i_char),
        .i_parity_check(i_parity_check), .i_start(i_start), .o_word_address_lines(addr),
        .o_gate_select_high(gsh), .o_gate_program_level(gpl), .o_second_chip_select(cs2),
        .o_output_program_level(supply), .o_load_sense(load), .o_power_on(pwr), .i_prom_data(prom_data),
        .o_busy(busy), .o_done(done), .o_fail(fail), .o_extra_fuse(extra), .o_cooling(cooling),
        .o_tape_done(tdone), .o_format_err(ferr), .o_parity_err(perr));
    prom_model model (
        .i_sys_clk(i_sys_clk), .i_addr(addr), .i_gate_high(gsh), .i_gate_prog(gpl), .i_cs2(cs2),
        .i_supply(supply), .i_power(pwr), .i_stuck(stuck), .o_data(prom_data));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic reset_dut;
        @(negedge i_sys_clk);
        i_rst_n = 1'b0;
        repeat (20) @(negedge i_sys_clk);
        i_rst_n   = 1'b1;
        cool_seen = 1'b0;
    endtask : reset_dut
    // bad flips bit 7 so the character carries odd parity
    task automatic send(input logic [6:0] c, input logic bad);
        @(negedge i_sys_clk);
        i_char       = {(^c) ^ bad, c};
        i_char_valid = 1'b1;
        @(negedge i_sys_clk);
        i_char_valid = 1'b0;
    endtask : send
    task automatic rubouts(input int n);
        for (int i = 0; i < n; i++) send(fuse_prog_pkg::CH_RUBOUT, 1'b0);
    endtask : rubouts
    function automatic logic [3:0] pattern(input int a);
        return (a == 0) ? 4'h1 : ((a == 3) ? 4'h8 : 4'h0);
    endfunction : pattern
    task automatic send_tape;
        rubouts(25);
        for (int a = 0; a < 256; a++) begin
            if (a == 1) begin
                send(fuse_prog_pkg::CH_BEGIN, 1'b0);
                send(fuse_prog_pkg::CH_HIGH, 1'b0);
                send(fuse_prog_pkg::CH_HIGH, 1'b0);
                rubouts(3);
            end
            send(fuse_prog_pkg::CH_BEGIN, 1'b0);
            for (int b = 3; b >= 0; b--) send(pattern(a)[b] ? fuse_prog_pkg::CH_HIGH : fuse_prog_pkg::CH_LOW, 1'b0);
            send(fuse_prog_pkg::CH_FINISH, 1'b0);
            send(7'h0D, 1'b0);
            send(7'h0A, 1'b0);
        end
        rubouts(25);
    endtask : send_tape
    task automatic run_prog;
        @(negedge i_sys_clk);
        i_start = 1'b1;
        @(negedge i_sys_clk);
        i_start = 1'b0;
        for (int n = 0; n < 90000 && done !== 1'b1 && fail !== 1'b1; n++) @(negedge i_sys_clk);
    endtask : run_prog
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_format;
        reset_dut();
        check({gpl, supply, pwr, cs2}, 8'h01);
        i_parity_check = 1'b1;
        rubouts(25);
        send(fuse_prog_pkg::CH_BEGIN, 1'b0);
        send(fuse_prog_pkg::CH_HIGH, 1'b0);
        send(7'h58, 1'b0);
        send(fuse_prog_pkg::CH_FINISH, 1'b0);
        @(negedge i_sys_clk);
        check({7'h00, ferr}, 8'h01);
        check({7'h00, perr}, 8'h00);
        send(fuse_prog_pkg::CH_BEGIN, 1'b1);
        @(negedge i_sys_clk);
        check({7'h00, perr}, 8'h01);
        check({7'h00, tdone}, 8'h00);
        $display("test format done");
    endtask : t_format
    task automatic t_fail;
        reset_dut();
        i_parity_check = 1'b0;
        stuck          = 1'b1;
        send_tape();
        check({7'h00, tdone}, 8'h01);
        run_prog();
        check({6'h00, fail, done}, 8'h02);
        check({7'h00, cool_seen}, 8'h01);
        stuck = 1'b0;
        $display("test fail done");
    endtask : t_fail
    task automatic t_program;
        reset_dut();
        i_parity_check = 1'b1;
        send_tape();
        check({5'h00, tdone, ferr, perr}, 8'h04);
        run_prog();
        check({4'h0, busy, done, fail, extra}, 8'h04);
        for (int a = 0; a < 256; a++) check({4'h0, model.blown_reg[a]}, {4'h0, pattern(a)});
        $display("test program done");
    endtask : t_program
    initial begin
        i_rst_n        = 1'b0;
        i_char_valid   = 1'b0;
        i_char         = 8'h00;
        i_parity_check = 1'b0;
        i_start        = 1'b0;
        stuck          = 1'b0;
        cool_seen      = 1'b0;
        t_format();
        t_fail();
        t_program();
        end_sim();
    end
    initial begin
        repeat (99000) @(posedge i_sys_clk);
        errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule : fuse_prog_sequencer_tb_top
`default_nettype wire
